// >>> rtl/lsfs_pkg.sv
package lsfs_pkg;
	// clock rate and interval figures
	// 125 MHz, 10.5 ms and 661.5 ms
	localparam int unsigned CLK_HZ          = 32'h0773_5940;
	localparam int unsigned BLANK_US        = 32'h0000_2904;
	localparam int unsigned RETRY_US        = 32'h000A_17FC;
	localparam longint unsigned US_PER_S    = 64'h0000_0000_000F_4240;
	localparam longint unsigned BLANK_CYCLES_L =
		(longint'(BLANK_US) * longint'(CLK_HZ)) / US_PER_S;
	localparam longint unsigned RETRY_CYCLES_L =
		(longint'(RETRY_US) * longint'(CLK_HZ)) / US_PER_S;
	localparam int unsigned BLANK_CYCLES    = int'(BLANK_CYCLES_L);
	localparam int unsigned RETRY_CYCLES    = int'(RETRY_CYCLES_L);
	localparam int unsigned CNT_W           = 32;
	// limit select encodings (milliamps)
	localparam logic [9:0]  LIMIT_LOW_MA    = 10'h0C8;
	localparam logic [9:0]  LIMIT_HIGH_MA   = 10'h190;
	// fault policy
	localparam logic        POLICY_RETRY    = 1'b0;
	localparam logic        POLICY_LATCH    = 1'b1;
	// sequencer states
	typedef enum logic [4:0] {
		LSFS_OFF     = 5'b0_0001,
		LSFS_ON      = 5'b0_0010,
		LSFS_RETRY   = 5'b0_0100,
		LSFS_LATCHED = 5'b0_1000,
		LSFS_PROTECT = 5'b1_0000
	} lsfs_state_e;
endpackage

// >>> rtl/lsfs_sync.sv
`timescale 1ns/10ps
`default_nettype none
module lsfs_sync
	import lsfs_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	// async in, synced out
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_reg;

	// first stage is read only by the second
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1_reg <= '0;
			syncOut    <= '0;
		end else begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/lsfs_timer.sv
`timescale 1ns/10ps
`default_nettype none
module lsfs_timer
	import lsfs_pkg::*;
(
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	// control
	input  wire logic             run,
	input  wire logic [CNT_W-1:0] limit,
	// status
	output logic                  expired,
	output logic      [CNT_W-1:0] count
);
	// counts while run; clears to zero as soon as run drops
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
		end else if (!run) begin
			count <= '0;
		end else if (count < limit) begin
			count <= count + 1'b1;
		end
	end

	assign expired = run && (count + 1'b1 >= limit);
endmodule
`default_nettype wire

// >>> rtl/lsfs_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module lsfs_sequencer
	import lsfs_pkg::*;
#(
	parameter logic [CNT_W-1:0] BLANK_TICKS = CNT_W'(BLANK_CYCLES),
	parameter logic [CNT_W-1:0] RETRY_TICKS = CNT_W'(RETRY_CYCLES),
	parameter logic             POLICY      = POLICY_RETRY
) (
	// clock and reset (reset from supply lockout)
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	// host pins
	input  wire logic       enable,
	input  wire logic       limit_select,
	// analog condition detectors
	input  wire logic       overLimit200,
	input  wire logic       overLimit400,
	input  wire logic       reverseCurrent,
	input  wire logic       overvoltageLockout,
	input  wire logic       undervoltageLockout,
	input  wire logic       thermalShutdown,
	// power switch and open-drain fault pin
	output logic            switchOn_reg,
	output logic            faultOut_reg,
	output logic            faultOe_reg,
	// status
	output logic [9:0]      limitMa_reg,
	output lsfs_state_e     state_reg
);
	logic [6:0] pinSync;
	logic       enS;
	logic       limSelS;
	logic       ovl200S;
	logic       ovl400S;
	logic       revS;
	logic       ovloS;
	logic       uvloS;
	logic       otpS;
	logic       overCur;
	logic       hardFault;
	logic       blankRun;
	logic       retryRun;
	logic       blankDone;
	logic       retryDone;
	logic [CNT_W-1:0] blankCount;
	logic [CNT_W-1:0] retryCount;
	lsfs_state_e state_next;
	logic       switchOn_next;
	logic       faultLow_next;

	lsfs_sync #(.WIDTH(7)) u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.asyncIn  ({enable, limit_select, overLimit200, overLimit400,
		            reverseCurrent, overvoltageLockout, thermalShutdown}),
		.syncOut  (pinSync)
	);
	assign {enS, limSelS, ovl200S, ovl400S, revS, ovloS, otpS} = pinSync;

	// undervoltage kept apart so it never flags
	lsfs_sync #(.WIDTH(1)) u_sync_uv (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.asyncIn  (undervoltageLockout),
		.syncOut  (uvloS)
	);

	// threshold picked by select pin
	assign overCur   = limSelS ? ovl400S : ovl200S;
	// faults that bypass blanking
	assign hardFault = revS || ovloS || otpS;

	// blanking only while closed in forward overcurrent
	assign blankRun = enS && (state_reg == LSFS_ON) && overCur;
	assign retryRun = enS && (state_reg == LSFS_RETRY);

	lsfs_timer u_blank (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.run      (blankRun),
		.limit    (BLANK_TICKS),
		.expired  (blankDone),
		.count    (blankCount)
	);

	lsfs_timer u_retry (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.run      (retryRun),
		.limit    (RETRY_TICKS),
		.expired  (retryDone),
		.count    (retryCount)
	);

	// cycle flag: set when a retry cycle started, cleared on clean blanking
	logic cycling_reg;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cycling_reg <= 1'b0;
		end else if (!enS) begin
			cycling_reg <= 1'b0;
		end else if (state_reg == LSFS_ON && blankDone) begin
			cycling_reg <= 1'b1;
		end else if (state_reg == LSFS_ON && !overCur) begin
			cycling_reg <= 1'b0;
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LSFS_OFF: begin
				if (enS && !uvloS && !hardFault) begin
					state_next = LSFS_ON;
				end else if (enS && !uvloS && hardFault) begin
					// undervoltage_lockout wins, else off and protect would alternate
					state_next = LSFS_PROTECT;
				end
			end
			LSFS_ON: begin
				if (!enS || uvloS) begin
					state_next = LSFS_OFF;
				end else if (hardFault) begin
					state_next = LSFS_PROTECT;
				end else if (blankDone) begin
					state_next = (POLICY == POLICY_LATCH) ?
						LSFS_LATCHED : LSFS_RETRY;
				end
			end
			LSFS_RETRY: begin
				if (!enS || uvloS) begin
					state_next = LSFS_OFF;
				end else if (hardFault) begin
					state_next = LSFS_PROTECT;
				end else if (retryDone) begin
					state_next = LSFS_ON;
				end
			end
			LSFS_LATCHED: begin
				// only an enable drop or power cycle leaves here
				if (!enS) begin
					state_next = LSFS_OFF;
				end
			end
			LSFS_PROTECT: begin
				if (!enS || uvloS) begin
					state_next = LSFS_OFF;
				end else if (!hardFault) begin
					state_next = LSFS_ON;
				end
			end
			default: state_next = LSFS_OFF;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= LSFS_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// switch closed only in the on state
	assign switchOn_next = (state_next == LSFS_ON);

	always_comb begin
		faultLow_next = 1'b0;
		case (state_next)
			LSFS_RETRY:   faultLow_next = 1'b1;
			LSFS_LATCHED: faultLow_next = 1'b1;
			LSFS_PROTECT: faultLow_next = 1'b1;
			LSFS_ON:      faultLow_next = cycling_reg && overCur;
			default:      faultLow_next = 1'b0;
		endcase
		if (!enS) begin
			faultLow_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			switchOn_reg <= 1'b0;
			faultOe_reg  <= 1'b0;
			faultOut_reg <= 1'b0;
			limitMa_reg  <= LIMIT_LOW_MA;
		end else begin
			switchOn_reg <= switchOn_next;
			faultOe_reg  <= faultLow_next;
			faultOut_reg <= 1'b0;
			limitMa_reg  <= limSelS ? LIMIT_HIGH_MA : LIMIT_LOW_MA;
		end
	end

	// checks
	property p_hard_off;
		@(posedge core_clk) disable iff (!reset_n)
		(enS && hardFault && !uvloS) |=> !switchOn_reg && faultOe_reg;
	endproperty
	a_hard_off: assert property (p_hard_off)
		else $error("hard fault left switch on");
	property p_overvoltage_lockout;
		@(posedge core_clk) disable iff (!reset_n)
		(state_reg == LSFS_ON && enS && !uvloS && ovloS)
			|=> state_reg == LSFS_PROTECT && faultOe_reg;
	endproperty
	a_overvoltage_lockout: assert property (p_overvoltage_lockout)
		else $error("overvoltage waited");
	property p_resume;
		@(posedge core_clk) disable iff (!reset_n)
		(state_reg == LSFS_PROTECT && enS && !uvloS && !hardFault)
			|=> switchOn_reg;
	endproperty
	a_resume: assert property (p_resume)
		else $error("no resume after hard fault");
	property p_en_low;
		@(posedge core_clk) disable iff (!reset_n)
		!enS |=> !switchOn_reg && !faultOe_reg;
	endproperty
	a_en_low: assert property (p_en_low)
		else $error("enable low not honoured");
	property p_undervoltage_lockout;
		@(posedge core_clk) disable iff (!reset_n)
		uvloS |=> !switchOn_reg;
	endproperty
	a_undervoltage_lockout: assert property (p_undervoltage_lockout)
		else $error("undervoltage left switch on");
	property p_undervoltage_lockout_flag;
		@(posedge core_clk) disable iff (!reset_n)
		(uvloS && !hardFault && state_reg == LSFS_OFF) |=> !faultOe_reg;
	endproperty
	a_undervoltage_lockout_flag: assert property (p_undervoltage_lockout_flag)
		else $error("undervoltage_lockout flagged");
	property p_blank_exp;
		@(posedge core_clk) disable iff (!reset_n)
		(blankDone && state_reg == LSFS_ON && !hardFault && !uvloS)
			|=> !switchOn_reg && faultOe_reg;
	endproperty
	a_blank_exp: assert property (p_blank_exp)
		else $error("no trip");
	property p_blank_restart;
		@(posedge core_clk) disable iff (!reset_n)
		!blankRun |=> blankCount == '0;
	endproperty
	a_blank_restart: assert property (p_blank_restart)
		else $error("blank kept");
	// a forward overload must not trip before blanking ends
	property p_fwd_blanked;
		@(posedge core_clk) disable iff (!reset_n)
		(state_reg == LSFS_ON && enS && !uvloS && !hardFault && !blankDone)
			|=> switchOn_reg;
	endproperty
	a_fwd_blanked: assert property (p_fwd_blanked)
		else $error("tripped inside blanking");
	property p_retry_hold;
		@(posedge core_clk) disable iff (!reset_n)
		(state_reg == LSFS_RETRY && !retryDone && enS && !uvloS && !hardFault)
			|=> state_reg == LSFS_RETRY && !switchOn_reg;
	endproperty
	a_retry_hold: assert property (p_retry_hold)
		else $error("retry left");
	property p_retry_end;
		@(posedge core_clk) disable iff (!reset_n)
		(state_reg == LSFS_RETRY && retryDone && enS && !uvloS && !hardFault)
			|=> switchOn_reg;
	endproperty
	a_retry_end: assert property (p_retry_end)
		else $error("no reclose");
	property p_reclose_flag;
		@(posedge core_clk) disable iff (!reset_n)
		(state_reg == LSFS_RETRY && retryDone && overCur && enS && !uvloS
			&& !hardFault) |=> switchOn_reg && faultOe_reg;
	endproperty
	a_reclose_flag: assert property (p_reclose_flag)
		else $error("flag dropped while cycling");
	property p_latch;
		@(posedge core_clk) disable iff (!reset_n)
		(state_reg == LSFS_LATCHED && enS) |=> state_reg == LSFS_LATCHED;
	endproperty
	a_latch: assert property (p_latch)
		else $error("latch released");
	property p_limit;
		@(posedge core_clk) disable iff (!reset_n)
		limSelS |=> limitMa_reg == LIMIT_HIGH_MA;
	endproperty
	a_limit: assert property (p_limit)
		else $error("high limit not shown");
	property p_clear_en;
		@(posedge core_clk) disable iff (!reset_n)
		!enS |=> blankCount == '0 && retryCount == '0;
	endproperty
	a_clear_en: assert property (p_clear_en)
		else $error("interval counter kept");
	c_trip: cover property (@(posedge core_clk) disable iff (!reset_n)
		state_reg == LSFS_ON ##1 state_reg == LSFS_RETRY);
	c_latch: cover property (@(posedge core_clk) disable iff (!reset_n)
		state_reg == LSFS_LATCHED);
	c_protect: cover property (@(posedge core_clk) disable iff (!reset_n)
		state_reg == LSFS_PROTECT ##1 state_reg == LSFS_ON);
	c_reclose: cover property (@(posedge core_clk) disable iff (!reset_n)
		state_reg == LSFS_RETRY ##1 state_reg == LSFS_ON);
	c_undervoltage_lockout: cover property (@(posedge core_clk) disable iff (!reset_n)
		uvloS && enS && state_reg == LSFS_OFF);
endmodule
`default_nettype wire

// >>> tb/lsfs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host side of the open-drain fault pin; the pull-up wins when released
module lsfs_host_model (
	// from the block
	input  wire logic faultOe,
	input  wire logic faultOut,
	// pin level seen by the host
	output wire logic faultPin_n
);
	assign faultPin_n = faultOe ? faultOut : 1'b1;
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import lsfs_pkg::*;
	// short intervals keep the run small
	localparam logic [CNT_W-1:0] BLANK = 32'h0000_0014;
	localparam logic [CNT_W-1:0] RETRY = 32'h0000_0064;
	localparam int               BL    = 20;
	localparam int               RT    = 100;
	logic        core_clk = 1'b0;
	logic        reset_n  = 1'b0;
	logic        enable   = 1'b0;
	logic        limSel   = 1'b0;
	logic        ov200    = 1'b0;
	logic        ov400    = 1'b0;
	logic        revCur   = 1'b0;
	logic        ovLock   = 1'b0;
	logic        uvLock   = 1'b0;
	logic        hot      = 1'b0;
	logic        rSw, rOut, rOe, lSw, lOut, lOe;
	logic [9:0]  rMa, lMa;
	lsfs_state_e rSt, lSt;
	wire         rPin_n, lPin_n;
	int          err_count = 0;
	int          n_checks  = 0;
	int          n;
	always #4 core_clk = ~core_clk;
	lsfs_sequencer #(.BLANK_TICKS(BLANK), .RETRY_TICKS(RETRY),
		.POLICY(POLICY_RETRY)) lsfs_sequencer_inst (
		.core_clk(core_clk), .reset_n(reset_n), .enable(enable),
		.limit_select(limSel), .overLimit200(ov200), .overLimit400(ov400),
		.reverseCurrent(revCur), .overvoltageLockout(ovLock),
		.undervoltageLockout(uvLock), .thermalShutdown(hot),
		.switchOn_reg(rSw), .faultOut_reg(rOut), .faultOe_reg(rOe),
		.limitMa_reg(rMa), .state_reg(rSt));
	lsfs_sequencer #(.BLANK_TICKS(BLANK), .RETRY_TICKS(RETRY),
		.POLICY(POLICY_LATCH)) lsfs_sequencer_latch_inst (
		.core_clk(core_clk), .reset_n(reset_n), .enable(enable),
		.limit_select(limSel), .overLimit200(ov200), .overLimit400(ov400),
		.reverseCurrent(revCur), .overvoltageLockout(ovLock),
		.undervoltageLockout(uvLock), .thermalShutdown(hot),
		.switchOn_reg(lSw), .faultOut_reg(lOut), .faultOe_reg(lOe),
		.limitMa_reg(lMa), .state_reg(lSt));
	lsfs_host_model lsfs_host_model_inst (.faultOe(rOe), .faultOut(rOut),
		.faultPin_n(rPin_n));
	lsfs_host_model lsfs_host_latch_inst (.faultOe(lOe), .faultOut(lOut),
		.faultPin_n(lPin_n));
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp,
		input string msg);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	// counts cycles until the retry switch reaches level v, bounded
	task automatic wait_sw(input logic v, input int lim);
		n = 0;
		while (rSw !== v && n < lim) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic t_reset;
		chk(rSw, 0, "switch at reset");
		chk(rPin_n, 1, "pin at reset");
		chk(rMa, 10'h0C8, "limit at reset");
		chk(10'(rSt), 10'(LSFS_OFF), "state at reset");
		$display("reset done");
	endtask
	task automatic t_enable;
		enable <= 1'b1;
		cyc(6);
		chk(rSw, 1, "switch on");
		limSel <= 1'b1;
		ov200  <= 1'b1;
		cyc(BL + 40);
		chk(rMa, 10'h190, "limit high");
		chk(rPin_n, 1, "200mA ignored at 400");
		limSel <= 1'b0;
		ov200  <= 1'b0;
		cyc(6);
		chk(rMa, 10'h0C8, "limit low");
		$display("enable done");
	endtask
	task automatic t_blip;
		ov200 <= 1'b1;
		cyc(BL - 5);
		ov200 <= 1'b0;
		cyc(3);
		ov200 <= 1'b1;
		cyc(BL - 5);
		ov200 <= 1'b0;
		cyc(40);
		chk(rSw & lSw, 1, "short overload tripped");
		chk(rPin_n & lPin_n, 1, "short overload flagged");
		$display("blip done");
	endtask
	task automatic t_retry;
		limSel <= 1'b1;
		ov200  <= 1'b1;
		ov400  <= 1'b1;
		wait_sw(1'b0, 60);
		chk(10'(n >= BL && n <= BL + 8), 1, "blank length");
		cyc(1);
		chk(rPin_n, 0, "flag in retry");
		chk(lSw | lPin_n, 0, "latch off");
		wait_sw(1'b1, 200);
		chk(10'(n >= RT - 2 && n <= RT + 8), 1, "retry length");
		chk(rPin_n, 0, "flag while reclosed");
		wait_sw(1'b0, 60);
		chk(10'(n >= BL - 2 && n <= BL + 8), 1, "reclose length");
		ov200 <= 1'b0;
		ov400 <= 1'b0;
		wait_sw(1'b1, 200);
		cyc(BL + 10);
		chk(rSw, 1, "stays on");
		chk(rPin_n, 1, "flag released");
		chk(lSw, 0, "latch holds");
		enable <= 1'b0;
		cyc(6);
		chk(lPin_n, 1, "pin released");
		enable <= 1'b1;
		limSel <= 1'b0;
		cyc(6);
		chk(lSw, 1, "latch cleared");
		$display("retry done");
	endtask
	task automatic t_hard;
		for (int k = 0; k < 3; k++) begin
			revCur <= (k == 0);
			ovLock <= (k == 1);
			hot    <= (k == 2);
			cyc(5);
			chk({rSw, lSw, rPin_n, lPin_n}, 0, "no trip");
			revCur <= 1'b0;
			ovLock <= 1'b0;
			hot    <= 1'b0;
			cyc(6);
			chk({rSw, rPin_n}, 10'h003, "no resume");
		end
		$display("hard faults done");
	endtask
	task automatic t_misc;
		uvLock <= 1'b1;
		cyc(6);
		chk({rSw, rPin_n}, 10'h001, "undervoltage");
		uvLock <= 1'b0;
		cyc(6);
		chk(rSw, 1, "undervoltage exit");
		revCur <= 1'b1;
		cyc(6);
		enable <= 1'b0;
		cyc(6);
		chk({rSw, rPin_n}, 10'h001, "enable low fault");
		revCur <= 1'b0;
		enable <= 1'b1;
		cyc(6);
		ov200 <= 1'b1;
		cyc(BL - 5);
		enable <= 1'b0;
		cyc(3);
		enable <= 1'b1;
		cyc(BL - 5);
		chk({rSw, rPin_n}, 10'h003, "counter kept");
		ov200 <= 1'b0;
		$display("misc done");
	endtask
	initial begin
		cyc(12);
		reset_n <= 1'b1;
		cyc(2);
		t_reset();
		t_enable();
		t_blip();
		t_retry();
		t_hard();
		t_misc();
		end_of_test();
	end
	// whole run is well under this many cycles
	initial begin
		#(8 * 5000);
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
